// [rtl/cie_pkg.sv]
package cie_pkg;

	// register indices; byte address on the bus is four times the index
	localparam logic [7:0] IDX_RX_FLAGS = 8'h04;
	localparam logic [7:0] IDX_RX_IRQ_EN = 8'h05;
	localparam logic [7:0] IDX_TX_FLAGS = 8'h06;
	localparam logic [7:0] IDX_TX_IRQ_EN = 8'h07;
	localparam logic [7:0] IDX_ABORT_REQ = 8'h08;
	localparam logic [7:0] IDX_ABORT_ACK = 8'h09;
	localparam int IDX_LSB = 2;
	localparam int IDX_MSB = 9;

	// receiver interrupt enable fields
	localparam int BIT_WAKE_EN = 7;
	localparam int BIT_SC_EN = 6;
	localparam int RX_SENS_LSB = 4;
	localparam int TX_SENS_LSB = 2;
	localparam int BIT_OVR_EN = 1;
	localparam int BIT_RXF_EN = 0;

	// receiver flag register fields (same positions for flags)
	localparam int BIT_WAKE_FLAG = 7;
	localparam int BIT_SC_FLAG = 6;
	localparam int BIT_OVR_FLAG = 1;
	localparam int BIT_RXF_FLAG = 0;

	// reset values
	localparam logic [7:0] RX_IRQ_EN_RST = 8'h00;
	localparam logic [7:0] RX_IRQ_EN_KEEP = 8'h3c; // sensitivity fields survive init
	localparam logic [2:0] TX_EMPTY_RST = 3'h7;
	localparam logic [2:0] TX_BITS_RST = 3'h0;

	// error counter bands
	localparam logic [8:0] CNT_WARN_MAX = 9'h060;
	localparam logic [8:0] CNT_ERR_MAX = 9'h07f;
	localparam logic [8:0] CNT_BUSOFF_MAX = 9'h0ff;

	// bus state codes and sensitivity codes
	localparam logic [1:0] ST_OK = 2'h0;
	localparam logic [1:0] ST_WARN = 2'h1;
	localparam logic [1:0] ST_ERR = 2'h2;
	localparam logic [1:0] ST_BUSOFF = 2'h3;
	localparam logic [1:0] SENS_NONE = 2'h0;
	localparam logic [1:0] SENS_BUSOFF = 2'h1;

	typedef struct packed {
		logic [7:0] rx_irq_enable;
		logic [2:0] tx_irq_enable;
		logic [2:0] tx_buf_empty;
		logic [2:0] abort_req;
		logic [2:0] abort_ack;
		logic wake_flag;
		logic overrun_flag;
		logic rx_full_flag;
	} cie_main_state_t;

endpackage

// [rtl/cie_ifs.sv]
`timescale 1ns/1ps

// register access carried from the bus slave to the register file
interface cie_reg_if;
	logic [7:0] idx;
	logic [7:0] wdata;
	logic wr_stb;
	logic [7:0] rdata;
	logic mapped;
	modport slave (output idx, output wdata, output wr_stb, input rdata, input mapped);
	modport regs (input idx, input wdata, input wr_stb, output rdata, output mapped);
endinterface

// bus state tracking between the register file and the tracker
interface cie_core_if;
	logic [1:0] rx_sens;
	logic [1:0] tx_sens;
	logic flag_clear;
	logic [1:0] rx_state;
	logic [1:0] tx_state;
	logic flag;
	modport regs (output rx_sens, output tx_sens, output flag_clear,
		input rx_state, input tx_state, input flag);
	modport tracker (input rx_sens, input tx_sens, input flag_clear,
		output rx_state, output tx_state, output flag);
endinterface

// [rtl/cie_apb_slave.sv]
`timescale 1ns/1ps

module cie_apb_slave (
	input wire logic clock_in,
	input wire logic rst_b_in,
	input wire logic [11:0] paddr_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	cie_reg_if.slave reg_bus
);

	typedef struct packed {
		logic [31:0] prdata;
		logic err;
	} cie_apb_state_t;

	cie_apb_state_t state_reg;
	cie_apb_state_t state_next;
	logic aligned;

	assign aligned = (paddr_in[cie_pkg::IDX_LSB-1:0] == 2'h0);
	assign reg_bus.idx = paddr_in[cie_pkg::IDX_MSB:cie_pkg::IDX_LSB];
	assign reg_bus.wdata = pwdata_in[7:0];
	// zero wait states: the access phase always completes
	assign pready_out = psel_in & penable_in;
	assign reg_bus.wr_stb = psel_in & penable_in & pwrite_in & ~state_reg.err;
	assign prdata_out = state_reg.prdata;
	assign pslverr_out = psel_in & penable_in & state_reg.err;

	// read data and error are caught in the setup cycle so they leave a flop
	always_comb begin
		state_next = state_reg;
		if (psel_in & ~penable_in) begin
			state_next.err = ~(aligned & reg_bus.mapped);
			state_next.prdata = {24'h000000, reg_bus.rdata};
			if (pwrite_in | ~aligned | ~reg_bus.mapped) begin
				state_next.prdata = 32'h00000000;
			end
		end
	end

	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

endmodule

// [rtl/cie_status_track.sv]
`timescale 1ns/1ps

module cie_status_track (
	input wire logic clock_in,
	input wire logic rst_b_in,
	input wire logic [7:0] rx_err_count_in,
	input wire logic [8:0] tx_err_count_in,
	cie_core_if.tracker core
);

	typedef struct packed {
		logic [1:0] rx_state;
		logic [1:0] tx_state;
		logic flag;
	} cie_track_state_t;

	cie_track_state_t state_reg;
	cie_track_state_t state_next;
	logic busoff;
	logic [1:0] rx_now;
	logic [1:0] tx_now;

	// band an error count into a bus state code
	function automatic logic [1:0] band(input logic [8:0] cnt, input logic off);
		if (off) begin
			band = cie_pkg::ST_BUSOFF;
		end else if (cnt > cie_pkg::CNT_ERR_MAX) begin
			band = cie_pkg::ST_ERR;
		end else if (cnt > cie_pkg::CNT_WARN_MAX) begin
			band = cie_pkg::ST_WARN;
		end else begin
			band = cie_pkg::ST_OK;
		end
	endfunction

	// does a move between two states matter at this sensitivity
	function automatic logic sens_hit(input logic [1:0] sens, input logic [1:0] from,
		input logic [1:0] to);
		if (from == to || sens == cie_pkg::SENS_NONE) begin
			sens_hit = 1'b0;
		end else if (sens == cie_pkg::SENS_BUSOFF) begin
			sens_hit = (from == cie_pkg::ST_BUSOFF) | (to == cie_pkg::ST_BUSOFF);
		end else begin
			sens_hit = from[1] | to[1]; // 11 acts like 10
		end
	endfunction

	assign busoff = (tx_err_count_in > cie_pkg::CNT_BUSOFF_MAX);
	assign rx_now = band({1'b0, rx_err_count_in}, busoff);
	assign tx_now = band(tx_err_count_in, busoff);
	assign core.rx_state = state_reg.rx_state;
	assign core.tx_state = state_reg.tx_state;
	assign core.flag = state_reg.flag;

	// states follow the counters only while no change is pending, so the
	// reported states stay those that raised the flag until it is cleared
	always_comb begin
		state_next = state_reg;
		if (state_reg.flag) begin
			if (core.flag_clear) begin
				state_next.flag = 1'b0;
			end
		end else begin
			state_next.rx_state = rx_now;
			state_next.tx_state = tx_now;
			if (sens_hit(core.rx_sens, state_reg.rx_state, rx_now) |
				sens_hit(core.tx_sens, state_reg.tx_state, tx_now)) begin
				state_next.flag = 1'b1;
			end
		end
	end

	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

endmodule

// [rtl/cie_irq_flags.sv]
// Operation
// RULE_01: in init mode the receiver enable register is held at reset, writes ignored.
// RULE_02: receiver and transmitter sensitivity fields keep their values in init mode.
// RULE_03: receiver enable register always readable, writable only with both init bits low.
// RULE_04: wake enable bit 7 gates wake events onto the wake interrupt.
// RULE_05: status change enable bit 6 gates the status flag onto the error interrupt.
// RULE_06: receiver sensitivity bits 5:4 pick which receiver state changes raise the flag.
// RULE_07: transmitter sensitivity bits 3:2 pick which transmitter changes raise the flag.
// RULE_08: reported states track real states, updated only with no change pending.
// RULE_09: overrun enable bit 1 gates overrun onto the error interrupt.
// RULE_10: receive full enable bit 0 gates a received message onto the receive interrupt.
// RULE_11: software sets wake enable and wake function together to recover from stop.
// RULE_12: three empty flags in bits 2:0; one means empty, zero means scheduled.
// RULE_13: writing one clears an empty flag, zero ignored, never in init mode.
// RULE_14: a successful send sets that buffer's empty flag.
// RULE_15: a successful abort of a pending request sets that buffer's empty flag.
// RULE_16: an empty flag with its enable set holds the transmit interrupt.
// RULE_17: clearing an empty flag also clears that buffer's abort acknowledge.
// RULE_18: an empty flag becoming set clears that buffer's abort request.
// RULE_19: listen mode refuses empty flag clears and starts no transmission.
// RULE_20: buffer access is blocked while its empty flag is zero.
// RULE_21: in init mode the empty flag register is held at reset.
// RULE_22: counts band as ok, warning above 96, error above 127, bus-off above 255.
// RULE_23: a set status flag freezes the reported states until software clears it.
// RULE_24: sensitivity code 11 behaves as code 10.
// RULE_25: error interrupt is enabled status flag or enabled overrun, held as a level.
`timescale 1ns/1ps

module cie_irq_flags (
	input wire logic clock_in,
	input wire logic rst_b_in,
	// register bus
	input wire logic [11:0] paddr_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// mode inputs from the controller core
	input wire logic init_request_in,
	input wire logic init_ack_in,
	input wire logic listen_mode_in,
	// error counters from the protocol engine
	input wire logic [7:0] rx_err_count_in,
	input wire logic [8:0] tx_err_count_in,
	// one-cycle events from the protocol engine and receive fifo
	input wire logic wake_event_in,
	input wire logic overrun_event_in,
	input wire logic rx_full_event_in,
	input wire logic [2:0] tx_sent_in,
	input wire logic [2:0] abort_done_in,
	// interrupt requests
	output logic wake_irq_out,
	output logic err_irq_out,
	output logic rx_irq_out,
	output logic tx_irq_out,
	// towards the transmit scheduler and buffer access path
	output logic [2:0] tx_start_ok_out,
	output logic [2:0] abort_req_out,
	output logic [2:0] tx_buf_access_ok_out
);

	////////////////////////////////////////////////////////////////////////////////
	// sub blocks

	cie_reg_if reg_bus ();
	cie_core_if core ();

	cie_apb_slave u_apb (
		.clock_in(clock_in),
		.rst_b_in(rst_b_in),
		.paddr_in(paddr_in),
		.psel_in(psel_in),
		.penable_in(penable_in),
		.pwrite_in(pwrite_in),
		.pwdata_in(pwdata_in),
		.prdata_out(prdata_out),
		.pready_out(pready_out),
		.pslverr_out(pslverr_out),
		.reg_bus(reg_bus)
	);

	cie_status_track u_track (
		.clock_in(clock_in),
		.rst_b_in(rst_b_in),
		.rx_err_count_in(rx_err_count_in),
		.tx_err_count_in(tx_err_count_in),
		.core(core)
	);

	////////////////////////////////////////////////////////////////////////////////
	// declarations

	cie_pkg::cie_main_state_t state_reg;
	cie_pkg::cie_main_state_t state_next;

	logic init_mode;
	logic write_ok;
	logic wr_rx_flags;
	logic wr_rx_en;
	logic wr_tx_flags;
	logic wr_tx_en;
	logic wr_abort;
	logic [2:0] empty_clear;
	logic [2:0] empty_set;
	logic [2:0] abort_grant;
	logic [7:0] rx_flags_view;

	// the register file answers a byte to a register index
	function automatic logic [7:0] pad3(input logic [2:0] bits);
		pad3 = {5'h00, bits};
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// mode decode and write strobes

	// init mode holds only when request and acknowledge both stand high;
	// during the handshake (one high, one low), as in init mode, only the receiver flag register takes writes
	assign init_mode = init_request_in & init_ack_in;
	assign write_ok = ~init_request_in & ~init_ack_in; // see RULE_03

	assign wr_rx_flags = reg_bus.wr_stb & (reg_bus.idx == cie_pkg::IDX_RX_FLAGS);
	assign wr_rx_en = reg_bus.wr_stb & write_ok & (reg_bus.idx == cie_pkg::IDX_RX_IRQ_EN);
	assign wr_tx_flags = reg_bus.wr_stb & write_ok & (reg_bus.idx == cie_pkg::IDX_TX_FLAGS);
	assign wr_tx_en = reg_bus.wr_stb & write_ok & (reg_bus.idx == cie_pkg::IDX_TX_IRQ_EN);
	assign wr_abort = reg_bus.wr_stb & write_ok & (reg_bus.idx == cie_pkg::IDX_ABORT_REQ);

	////////////////////////////////////////////////////////////////////////////////
	// transmit buffer empty bookkeeping

	// a clear only acts on flags that are set; listen mode refuses all clears
	assign empty_clear = (wr_tx_flags & ~listen_mode_in) ?
		(reg_bus.wdata[2:0] & state_reg.tx_buf_empty) : 3'h0; // see RULE_13, see RULE_19

	// an abort is only honoured where a request is actually pending
	assign abort_grant = abort_done_in & state_reg.abort_req; // see RULE_15

	// a send and a granted abort both hand the buffer back to software
	assign empty_set = tx_sent_in | abort_grant; // see RULE_14, see RULE_15

	////////////////////////////////////////////////////////////////////////////////
	// status change link to the tracker

	// the tracker must see the sensitivity in init mode too, since it survives
	assign core.rx_sens = state_reg.rx_irq_enable[cie_pkg::RX_SENS_LSB+:2]; // see RULE_06
	assign core.tx_sens =
		state_reg.rx_irq_enable[cie_pkg::TX_SENS_LSB+:2]; // see RULE_07, see RULE_24
	assign core.flag_clear = wr_rx_flags & reg_bus.wdata[cie_pkg::BIT_SC_FLAG]; // see RULE_23

	////////////////////////////////////////////////////////////////////////////////
	// next state

	// each flag that hardware sets is updated as (old and not cleared) or set,
	// so an event landing in the clearing cycle survives the clear
	always_comb begin
		state_next = state_reg;

		// receiver side flags, write one to clear
		if (wr_rx_flags) begin
			state_next.wake_flag = state_reg.wake_flag & ~reg_bus.wdata[cie_pkg::BIT_WAKE_FLAG];
			state_next.overrun_flag = state_reg.overrun_flag &
				~reg_bus.wdata[cie_pkg::BIT_OVR_FLAG];
			state_next.rx_full_flag = state_reg.rx_full_flag &
				~reg_bus.wdata[cie_pkg::BIT_RXF_FLAG];
		end
		state_next.wake_flag = state_next.wake_flag | wake_event_in;
		state_next.overrun_flag = state_next.overrun_flag | overrun_event_in;
		state_next.rx_full_flag = state_next.rx_full_flag | rx_full_event_in;

		// enables take software writes only while init request and acknowledge are both low
		if (wr_rx_en) begin
			state_next.rx_irq_enable = reg_bus.wdata; // see RULE_03
		end
		if (wr_tx_en) begin
			state_next.tx_irq_enable = reg_bus.wdata[2:0];
		end

		// empty flags: set wins over a clear in the same cycle
		state_next.tx_buf_empty = (state_reg.tx_buf_empty & ~empty_clear) | empty_set; // see RULE_12

		// acknowledge falls with the clear of its empty flag, rises on a grant
		state_next.abort_ack = (state_reg.abort_ack & ~empty_clear) | abort_grant; // see RULE_17

		// software may only raise requests, and only for scheduled buffers;
		// a buffer that is (or becomes) empty drops its request
		if (wr_abort) begin
			state_next.abort_req = state_reg.abort_req |
				(reg_bus.wdata[2:0] & ~state_reg.tx_buf_empty);
		end
		state_next.abort_req = state_next.abort_req & ~state_next.tx_buf_empty; // see RULE_18

		// init mode overrides the enables, empty flags and abort bits, except the sensitivity fields
		if (init_mode) begin
			state_next.rx_irq_enable = (cie_pkg::RX_IRQ_EN_RST & ~cie_pkg::RX_IRQ_EN_KEEP) |
				(state_reg.rx_irq_enable & cie_pkg::RX_IRQ_EN_KEEP); // see RULE_01, see RULE_02
			state_next.tx_buf_empty = cie_pkg::TX_EMPTY_RST; // see RULE_21
			state_next.tx_irq_enable = cie_pkg::TX_BITS_RST;
			state_next.abort_req = cie_pkg::TX_BITS_RST;
			state_next.abort_ack = cie_pkg::TX_BITS_RST;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_reg.rx_irq_enable <= cie_pkg::RX_IRQ_EN_RST;
			state_reg.tx_irq_enable <= cie_pkg::TX_BITS_RST;
			state_reg.tx_buf_empty <= cie_pkg::TX_EMPTY_RST;
			state_reg.abort_req <= cie_pkg::TX_BITS_RST;
			state_reg.abort_ack <= cie_pkg::TX_BITS_RST;
			state_reg.wake_flag <= 1'b0;
			state_reg.overrun_flag <= 1'b0;
			state_reg.rx_full_flag <= 1'b0;
		end else begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read side

	// receiver flag view: sticky flags around the frozen bus states
	always_comb begin
		rx_flags_view = 8'h00;
		rx_flags_view[cie_pkg::BIT_WAKE_FLAG] = state_reg.wake_flag;
		rx_flags_view[cie_pkg::BIT_SC_FLAG] = core.flag;
		rx_flags_view[cie_pkg::RX_SENS_LSB+:2] = core.rx_state; // see RULE_08, see RULE_22
		rx_flags_view[cie_pkg::TX_SENS_LSB+:2] = core.tx_state; // see RULE_08
		rx_flags_view[cie_pkg::BIT_OVR_FLAG] = state_reg.overrun_flag;
		rx_flags_view[cie_pkg::BIT_RXF_FLAG] = state_reg.rx_full_flag;
	end

	// reads never have side effects; unmapped indices answer with an error
	always_comb begin
		reg_bus.rdata = 8'h00;
		reg_bus.mapped = 1'b1;
		case (reg_bus.idx)
			cie_pkg::IDX_RX_FLAGS: begin
				reg_bus.rdata = rx_flags_view;
			end
			cie_pkg::IDX_RX_IRQ_EN: begin
				reg_bus.rdata = state_reg.rx_irq_enable; // see RULE_03
			end
			cie_pkg::IDX_TX_FLAGS: begin
				reg_bus.rdata = pad3(state_reg.tx_buf_empty);
			end
			cie_pkg::IDX_TX_IRQ_EN: begin
				reg_bus.rdata = pad3(state_reg.tx_irq_enable);
			end
			cie_pkg::IDX_ABORT_REQ: begin
				reg_bus.rdata = pad3(state_reg.abort_req);
			end
			cie_pkg::IDX_ABORT_ACK: begin
				reg_bus.rdata = pad3(state_reg.abort_ack);
			end
			default: begin
				reg_bus.mapped = 1'b0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// interrupt requests

	// all requests are levels that stand until software clears the cause;
	// the wake request alone does not bring the part out of stop, the wake
	// function enable in the control block must be set as well
	assign wake_irq_out = state_reg.wake_flag &
		state_reg.rx_irq_enable[cie_pkg::BIT_WAKE_EN]; // see RULE_04

	// status change and overrun share the error request
	assign err_irq_out = (core.flag & state_reg.rx_irq_enable[cie_pkg::BIT_SC_EN]) |
		(state_reg.overrun_flag & state_reg.rx_irq_enable[cie_pkg::BIT_OVR_EN]); // see RULE_05, see RULE_09, see RULE_25

	assign rx_irq_out = state_reg.rx_full_flag &
		state_reg.rx_irq_enable[cie_pkg::BIT_RXF_EN]; // see RULE_10

	assign tx_irq_out = |(state_reg.tx_buf_empty & state_reg.tx_irq_enable); // see RULE_16

	////////////////////////////////////////////////////////////////////////////////
	// transmit scheduler and buffer access

	// a scheduled buffer may start only outside listen mode
	assign tx_start_ok_out = ~state_reg.tx_buf_empty & {3{~listen_mode_in}}; // see RULE_19

	// a buffer handed to the scheduler is locked against software access
	assign tx_buf_access_ok_out = state_reg.tx_buf_empty; // see RULE_20

	assign abort_req_out = state_reg.abort_req;

endmodule

// [testbench/cie_irq_flags_checker.sv]
`timescale 1ns/1ps

// top ports only, one clock
module cie_irq_flags_checker (
	input logic clock_in,
	input logic rst_b_in,
	input logic psel_in,
	input logic penable_in,
	input logic pready_out,
	input logic pslverr_out,
	input logic init_request_in,
	input logic init_ack_in,
	input logic listen_mode_in,
	input logic [2:0] tx_sent_in,
	input logic [2:0] abort_done_in,
	input logic wake_irq_out,
	input logic err_irq_out,
	input logic rx_irq_out,
	input logic tx_irq_out,
	input logic [2:0] tx_start_ok_out,
	input logic [2:0] abort_req_out,
	input logic [2:0] tx_buf_access_ok_out
);
	logic [2:0] aborted;

	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rst_b_in);

	// aborts that are really granted: a done pulse with no request is ignored
	assign aborted = abort_done_in & abort_req_out;

	////////////////////////////////////////////////////////////////////////////////
	property p_ready; pready_out == (psel_in && penable_in); endproperty
	a_ready: assert property (p_ready) else $error("pready off the access phase");
	property p_slverr; pslverr_out |-> psel_in && penable_in; endproperty
	a_slverr: assert property (p_slverr) else $error("pslverr outside access");
	property p_start; tx_start_ok_out == (~tx_buf_access_ok_out & {3{!listen_mode_in}}); endproperty
	a_start: assert property (p_start) else $error("start gating wrong");
	property p_sent; |tx_sent_in |=> (tx_buf_access_ok_out & $past(tx_sent_in)) == $past(tx_sent_in); endproperty
	a_sent: assert property (p_sent) else $error("sent buffer not empty");
	property p_sent_drop; |tx_sent_in |=> (abort_req_out & $past(tx_sent_in)) == 3'h0; endproperty
	a_sent_drop: assert property (p_sent_drop) else $error("abort request kept");
	property p_abort; |aborted |=> (tx_buf_access_ok_out & $past(aborted)) == $past(aborted); endproperty
	a_abort: assert property (p_abort) else $error("aborted buffer not empty");
	property p_init; init_request_in && init_ack_in |=> tx_buf_access_ok_out == 3'h7
		&& abort_req_out == 3'h0 && !(wake_irq_out || err_irq_out || rx_irq_out || tx_irq_out); endproperty
	a_init: assert property (p_init) else $error("init mode not held");
	property p_listen; listen_mode_in |=> (~tx_buf_access_ok_out & $past(tx_buf_access_ok_out)) == 3'h0; endproperty
	a_listen: assert property (p_listen) else $error("flag cleared in listen");
endmodule

bind cie_irq_flags cie_irq_flags_checker u_chk (.*);

// [testbench/cie_engine_model.sv]
`timescale 1ns/1ps

// stand-in for the protocol engine: sends or aborts the lowest scheduled buffer
module cie_engine_model (
	input logic clock_in,
	input logic rst_b_in,
	input logic go_in,
	input logic [3:0] delay_in,
	input logic [2:0] start_ok_in,
	input logic [2:0] abort_req_in,
	output logic [2:0] tx_sent_out,
	output logic [2:0] abort_done_out
);
	logic [3:0] wait_cnt;
	logic [2:0] pick;

	// listen mode starves us
	assign pick = start_ok_in & (~start_ok_in + 3'h1);

	// count out the frame time, then report the outcome for one cycle
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			wait_cnt <= 4'h0;
			tx_sent_out <= 3'h0;
			abort_done_out <= 3'h0;
		end else begin
			tx_sent_out <= 3'h0;
			abort_done_out <= 3'h0;
			// rest a cycle after a report so the flag update is seen first
			if (!go_in || pick == 3'h0 || tx_sent_out != 3'h0 || abort_done_out != 3'h0) begin
				wait_cnt <= 4'h0;
			end else if (wait_cnt >= delay_in) begin
				wait_cnt <= 4'h0;
				abort_done_out <= pick & abort_req_in;
				tx_sent_out <= pick & ~abort_req_in;
			end else begin
				wait_cnt <= wait_cnt + 4'h1;
			end
		end
	end
endmodule

// [testbench/test_can_irq_enable_and_tx_empty_flags.sv]
`timescale 1ns/1ps

module test_can_irq_enable_and_tx_empty_flags;
	localparam logic [11:0] A_RXF = 12'h010, A_EN = 12'h014, A_TXF = 12'h018;
	localparam logic [11:0] A_TIE = 12'h01c, A_ARQ = 12'h020, A_ACK = 12'h024;
	logic clock_in, rst_b_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out, err, go;
	logic [11:0] paddr_in;
	logic [31:0] pwdata_in, prdata_out, rd, seed;
	logic init_request_in, init_ack_in, listen_mode_in;
	logic [7:0] rx_err_count_in, v;
	logic [8:0] tx_err_count_in;
	logic wake_event_in, overrun_event_in, rx_full_event_in;
	logic wake_irq_out, err_irq_out, rx_irq_out, tx_irq_out;
	logic [2:0] tx_sent_in, abort_done_in, tx_start_ok_out, abort_req_out, tx_buf_access_ok_out;
	logic [3:0] delay;
	logic [7:0] bitm [3] = '{8'h80, 8'h02, 8'h01};
	int miscompares, check_count;

	cie_irq_flags dut (.*);
	cie_engine_model engine (.clock_in, .rst_b_in, .go_in(go), .delay_in(delay),
		.start_ok_in(tx_start_ok_out), .abort_req_in(abort_req_out), .tx_sent_out(tx_sent_in),
		.abort_done_out(abort_done_in));

	// free-running module clock
	initial begin
		clock_in = 1'b0;
		forever #5 clock_in = ~clock_in;
	end

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// expected bus state code from a counter; bus-off wins over the bands
	function automatic logic [1:0] band(input logic [8:0] c, input logic off);
		return off ? 2'h3 : (c > 127) ? 2'h2 : (c > 96) ? 2'h1 : 2'h0;
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// one apb transfer, bounded by the watchdog
	task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d);
		@(posedge clock_in);
		psel_in <= 1'b1;
		penable_in <= 1'b0;
		paddr_in <= a;
		pwrite_in <= w;
		pwdata_in <= {24'h0, d};
		@(posedge clock_in);
		penable_in <= 1'b1;
		@(posedge clock_in);
		while (pready_out !== 1'b1) @(posedge clock_in);
		rd = prdata_out;
		err = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
		#1;
	endtask
	task automatic rdc(input logic [11:0] a, input logic [7:0] e);
		apb(a, 1'b0, 8'h00);
		chk(rd, {24'h0, e});
	endtask
	task automatic ev(input logic [2:0] m);
		@(posedge clock_in);
		{wake_event_in, overrun_event_in, rx_full_event_in} <= m;
		@(posedge clock_in);
		{wake_event_in, overrun_event_in, rx_full_event_in} <= 3'h0;
		#1;
	endtask
	task automatic wait_empty(input int i);
		for (int n = 0; n < 40 && tx_buf_access_ok_out[i] !== 1'b1; n++) @(posedge clock_in);
		#1;
	endtask
	task automatic set_go(input logic g, input logic l);
		@(posedge clock_in);
		go <= g;
		listen_mode_in <= l;
		#1;
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// watchdog, far above the run length
	initial begin
		repeat (20000) @(posedge clock_in);
		miscompares++;
		end_of_test();
	end

	initial begin
		{rst_b_in, psel_in, penable_in, pwrite_in, paddr_in, pwdata_in, go} = '0;
		{init_request_in, init_ack_in, listen_mode_in, rx_err_count_in, tx_err_count_in} = '0;
		{wake_event_in, overrun_event_in, rx_full_event_in} = 3'h0;
		seed = 32'h69d3;
		delay = 4'h1;
		repeat (16) @(posedge clock_in);
		rst_b_in <= 1'b1;
		rdc(A_EN, cie_pkg::RX_IRQ_EN_RST);
		rdc(A_TXF, {5'h0, cie_pkg::TX_EMPTY_RST});
		rdc(A_ACK, 8'h00);
		chk(tx_buf_access_ok_out, 3'h7);
		$display("test reset values done");
		for (int i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			apb(A_EN, 1'b1, seed[7:0]);
			rdc(A_EN, seed[7:0]);
		end
		apb(12'h03c, 1'b0, 8'h00);
		chk(err, 1'b1);
		chk(rd, 32'h0);
		apb(A_EN | 12'h001, 1'b1, 8'hff);
		chk(err, 1'b1);
		$display("test register access done");
		v = seed[7:0];
		set_go(1'b0, 1'b0);
		init_request_in <= 1'b1;
		apb(A_EN, 1'b1, ~v);
		rdc(A_EN, v);
		init_ack_in <= 1'b1;
		rdc(A_EN, v & cie_pkg::RX_IRQ_EN_KEEP);
		apb(A_EN, 1'b1, 8'hff);
		rdc(A_EN, v & cie_pkg::RX_IRQ_EN_KEEP);
		rdc(A_TXF, 8'h07);
		{init_request_in, init_ack_in} <= 2'b00;
		$display("test init mode done");
		apb(A_EN, 1'b1, 8'hc3);
		for (int i = 0; i < 3; i++) begin
			ev(3'b100 >> i);
			chk({wake_irq_out, err_irq_out, rx_irq_out}, 3'b100 >> i);
			apb(A_EN, 1'b1, 8'hc3 ^ bitm[i]);
			chk({wake_irq_out, err_irq_out, rx_irq_out}, 3'h0);
			apb(A_RXF, 1'b1, bitm[i]);
			apb(A_EN, 1'b1, 8'hc3);
			chk({wake_irq_out, err_irq_out, rx_irq_out}, 3'h0);
		end
		$display("test interrupt enables done");
		apb(A_TIE, 1'b1, 8'h01);
		chk(tx_irq_out, 1'b1);
		apb(A_TXF, 1'b1, 8'h00);
		rdc(A_TXF, 8'h07);
		apb(A_TXF, 1'b1, 8'h01);
		chk({tx_irq_out, tx_start_ok_out, tx_buf_access_ok_out}, 7'h0e);
		set_go(1'b1, 1'b0);
		wait_empty(0);
		chk(tx_irq_out, 1'b1);
		set_go(1'b0, 1'b0);
		delay <= 4'h9;
		apb(A_TXF, 1'b1, 8'h02);
		apb(A_ARQ, 1'b1, 8'h02);
		chk(abort_req_out, 3'h2);
		set_go(1'b1, 1'b0);
		wait_empty(1);
		chk({tx_buf_access_ok_out, abort_req_out}, 6'h38);
		rdc(A_ACK, 8'h02);
		set_go(1'b0, 1'b0);
		apb(A_TXF, 1'b1, 8'h02);
		rdc(A_ACK, 8'h00);
		set_go(1'b1, 1'b1);
		chk(tx_start_ok_out, 3'h0);
		apb(A_TXF, 1'b1, 8'h05);
		rdc(A_TXF, 8'h05);
		set_go(1'b1, 1'b0);
		wait_empty(1);
		chk(tx_buf_access_ok_out, 3'h7);
		$display("test transmit flags done");
		apb(A_EN, 1'b1, 8'h50);
		tx_err_count_in <= 9'h100;
		repeat (3) @(posedge clock_in);
		#1;
		chk(err_irq_out, 1'b1);
		rdc(A_RXF, {2'b01, band(9'h0, 1'b1), band(9'h100, 1'b1), 2'b00});
		tx_err_count_in <= 9'h000;
		repeat (3) @(posedge clock_in);
		rdc(A_RXF, {2'b01, band(9'h0, 1'b1), band(9'h100, 1'b1), 2'b00});
		apb(A_RXF, 1'b1, 8'h40);
		repeat (3) @(posedge clock_in);
		rdc(A_RXF, {2'b01, band(9'h0, 1'b0), band(9'h0, 1'b0), 2'b00});
		apb(A_EN, 1'b1, 8'h40);
		apb(A_RXF, 1'b1, 8'h40);
		rx_err_count_in <= 8'd100;
		repeat (3) @(posedge clock_in);
		rdc(A_RXF, {2'b00, band(9'd100, 1'b0), band(9'h0, 1'b0), 2'b00});
		chk(err_irq_out, 1'b0);
		apb(A_EN, 1'b1, 8'h70);
		rx_err_count_in <= 8'd200;
		repeat (3) @(posedge clock_in);
		#1;
		chk(err_irq_out, 1'b1);
		$display("test bus state done");
		end_of_test();
	end
endmodule
